/* File: shared/scr_params.svh */
// named constants for the sensor conversion readout block
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

`define SCR_TARGET_ADDR 7'h76
`define SCR_CMD_ADC_READ 8'h00
`define SCR_CMD_KIND_PRESS 4'h4
`define SCR_CMD_KIND_TEMP 4'h5
`define SCR_OSR_CODE_MAX 3'h5
`define SCR_RESULT_W 24
`define SCR_LAST_BIT 3'h7
`define SCR_LAST_BYTE 2'h2
`define SCR_ZERO_RESULT 24'h000000
`define SCR_COUNT_ZERO 32'h00000000
`define SCR_COUNT_ONE 32'h00000001
`define SCR_CONV_BASE_CYCLES 1000

`endif

/* File: shared/scr_pkg.sv */
// types shared by the sensor conversion readout block
`default_nettype none
`include "scr_params.svh"

package scr_pkg;

    // bus-side protocol states
    typedef enum logic [2:0] {
        SCR_IDLE,
        SCR_ADDR,
        SCR_ADDR_ACK,
        SCR_CMD,
        SCR_CMD_ACK,
        SCR_TX,
        SCR_TX_MACK
    } scr_state_t;

    // open-drain data pin drive pair
    typedef struct packed {
        logic drive;
        logic level;
    } scr_sda_t;

    // the two raw samples offered by the analog front end
    typedef struct packed {
        logic [`SCR_RESULT_W-1:0] pressure;
        logic [`SCR_RESULT_W-1:0] temperature;
    } scr_samples_t;

    // all state of the readout block except the two pin synchronisers
    typedef struct packed {
        scr_state_t st;
        logic [2:0] bitCnt;
        logic [1:0] byteCnt;
        logic [7:0] shift;
        logic readDir;
        logic ackOn;
        logic gotAck;
        logic [`SCR_RESULT_W-1:0] txWord;
        scr_sda_t sda;
        logic sclPrev;
        logic sdaPrev;
        logic readArmed;
        logic busy;
        logic [31:0] convCnt;
        logic convTemp;
        logic corrupt;
        logic [`SCR_RESULT_W-1:0] result;
        logic resultValid;
        logic resultCorrupt;
    } scr_regs_t;

endpackage

`default_nettype wire

/* File: hw/scr_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module scr_sync2 #(
    parameter int WIDTH = 1
) (
    clk_sys, // system clock
    resetn, // async reset, active low
    asyncIn, // input from outside the clock domain
    syncOut // synchronised copy
);
    input wire logic clk_sys;
    input wire logic resetn;
    input wire logic [WIDTH-1:0] asyncIn;
    output logic [WIDTH-1:0] syncOut;

    // state: first stage and second stage
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } scr_sync_t;

    scr_sync_t r_reg; // registered state
    scr_sync_t r_next; // next state

    ////////////////////////////////////////////////////////////////////////
    // next state: first stage is read only by the second
    always_comb begin
        r_next = r_reg;
        r_next.meta = asyncIn;
        r_next.stable = r_reg.meta;
    end

    // register the state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign syncOut = r_reg.stable;
endmodule

`default_nettype wire

/* File: hw/scr_readout.sv */
// two-wire bus target that starts conversions and reads out 24-bit results
// Overview of operation
// [RQ1] conversion command starts pressure or temperature sample
// [RQ2] result shifted out most significant bit first
// [RQ3] no conversion or repeated read returns zero
// [RQ4] read during conversion gives zero, result corrupted
// [RQ5] controller never restarts a running conversion
// [RQ6] busy from command until conversion completes
// [RQ7] controller clocks 24 result bits after acknowledge
// [RQ8] acknowledge from controller after each byte
// [RQ9] target address 1110110, last bit read/write
// [RQ10] one-byte commands: 0x40, 0x50, read 0x00
// [RQ11] controller frames transactions with start and stop
// [RQ12] controller waits conversion time, nacks last byte
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"

module scr_readout #(
    parameter int unsigned CONV_BASE_CYCLES = `SCR_CONV_BASE_CYCLES
) (
    clk_sys, // system clock, 100 MHz
    resetn, // async reset, active low
    sclIn, // bus clock pin
    sdaIn, // bus data pin, level seen
    samples, // raw samples from analog front end
    sdaOut, // bus data pin, driven level
    sdaOe, // bus data pin, drive enable
    convBusy, // conversion in progress
    resultValid, // unread result waiting
    resultCorrupt // stored result marked corrupted
);
    input wire logic clk_sys;
    input wire logic resetn;
    input wire logic sclIn;
    input wire logic sdaIn;
    input wire scr_pkg::scr_samples_t samples;
    output logic sdaOut;
    output logic sdaOe;
    output logic convBusy;
    output logic resultValid;
    output logic resultCorrupt;

    scr_pkg::scr_regs_t r_reg; // registered state
    scr_pkg::scr_regs_t r_next; // next state
    logic sclS; // synchronised bus clock
    logic sdaS; // synchronised bus data
    logic sclRise; // bus clock rising edge
    logic sclFall; // bus clock falling edge
    logic startCond; // data falls while clock high
    logic stopCond; // data rises while clock high
    logic [7:0] inByte; // byte completed on this rising edge
    logic isConvCmd; // completed byte is a conversion command

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    scr_sync2 #(.WIDTH(1)) u_syncScl (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .asyncIn(sclIn),
        .syncOut(sclS)
    );

    scr_sync2 #(.WIDTH(1)) u_syncSda (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .asyncIn(sdaIn),
        .syncOut(sdaS)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge and condition detection on synchronised pins
    assign sclRise = sclS & ~r_reg.sclPrev;
    assign sclFall = ~sclS & r_reg.sclPrev;
    assign startCond = sclS & r_reg.sclPrev & r_reg.sdaPrev & ~sdaS;
    assign stopCond = sclS & r_reg.sclPrev & ~r_reg.sdaPrev & sdaS;
    assign inByte = {r_reg.shift[6:0], sdaS};
    // conversion commands: kind nibble, legal ratio code, bit 0 clear
    assign isConvCmd = ((r_reg.shift[7:4] == `SCR_CMD_KIND_PRESS) || (r_reg.shift[7:4] == `SCR_CMD_KIND_TEMP))
        && (r_reg.shift[3:1] <= `SCR_OSR_CODE_MAX) && !r_reg.shift[0]; // RQ10

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.sclPrev = sclS;
        r_next.sdaPrev = sdaS;
        r_next.sda.level = 1'b0; // open drain: only ever pulls low

        // conversion timer; the result lands when the count runs out
        if (r_reg.busy) begin
            if (r_reg.convCnt == `SCR_COUNT_ZERO) begin
                r_next.busy = 1'b0; // RQ6
                r_next.result = r_reg.convTemp ? samples.temperature : samples.pressure; // RQ1
                r_next.resultValid = 1'b1; // RQ6
                r_next.resultCorrupt = r_reg.corrupt; // RQ4
            end else begin
                r_next.convCnt = r_reg.convCnt - `SCR_COUNT_ONE;
            end
        end

        // bus protocol; start and stop override any state
        if (startCond) begin
            r_next.st = scr_pkg::SCR_ADDR;
            r_next.bitCnt = 3'h0;
            r_next.ackOn = 1'b0;
            r_next.sda.drive = 1'b0;
        end else if (stopCond) begin
            r_next.st = scr_pkg::SCR_IDLE;
            r_next.sda.drive = 1'b0;
        end else begin
            case (r_reg.st)
                // address byte sampled on rising clock
                scr_pkg::SCR_ADDR: begin
                    if (sclRise) begin
                        r_next.shift = inByte;
                        r_next.bitCnt = r_reg.bitCnt + 3'h1;
                        if (r_reg.bitCnt == `SCR_LAST_BIT) begin
                            if (inByte[7:1] == `SCR_TARGET_ADDR) begin // RQ9
                                r_next.readDir = inByte[0]; // RQ9
                                r_next.st = scr_pkg::SCR_ADDR_ACK;
                            end else begin
                                r_next.st = scr_pkg::SCR_IDLE; // not ours
                            end
                        end
                    end
                end
                // address acknowledge, then load the result word for reads
                scr_pkg::SCR_ADDR_ACK: begin
                    if (sclFall) begin
                        if (!r_reg.ackOn) begin
                            r_next.ackOn = 1'b1;
                            r_next.sda.drive = 1'b1;
                        end else begin
                            r_next.ackOn = 1'b0;
                            r_next.bitCnt = 3'h0;
                            r_next.byteCnt = 2'h0;
                            if (r_reg.readDir) begin
                                // only the first read after a finished conversion sees data, even a corrupted one
                                if (r_reg.readArmed && r_reg.resultValid && !r_reg.busy) begin
                                    r_next.txWord = r_reg.result; // RQ2
                                    r_next.sda.drive = ~r_reg.result[`SCR_RESULT_W-1]; // RQ2
                                end else begin
                                    r_next.txWord = `SCR_ZERO_RESULT; // RQ3
                                    r_next.sda.drive = 1'b1; // RQ3
                                end
                                if (r_reg.readArmed && r_reg.busy) begin
                                    r_next.corrupt = 1'b1; // RQ4
                                end
                                r_next.readArmed = 1'b0; // RQ3
                                // a result landing in this very cycle wins over the clear
                                if (!r_reg.busy) begin
                                    r_next.resultValid = 1'b0; // RQ3
                                end
                                r_next.st = scr_pkg::SCR_TX; // RQ7
                            end else begin
                                r_next.sda.drive = 1'b0;
                                r_next.st = scr_pkg::SCR_CMD;
                            end
                        end
                    end
                end
                // command byte sampled on rising clock
                scr_pkg::SCR_CMD: begin
                    if (sclRise) begin
                        r_next.shift = inByte;
                        r_next.bitCnt = r_reg.bitCnt + 3'h1;
                        if (r_reg.bitCnt == `SCR_LAST_BIT) begin
                            r_next.st = scr_pkg::SCR_CMD_ACK;
                        end
                    end
                end
                // command acknowledge; the command acts when it ends
                scr_pkg::SCR_CMD_ACK: begin
                    if (sclFall) begin
                        if (!r_reg.ackOn) begin
                            r_next.ackOn = 1'b1;
                            r_next.sda.drive = 1'b1;
                        end else begin
                            r_next.ackOn = 1'b0;
                            r_next.sda.drive = 1'b0;
                            r_next.bitCnt = 3'h0;
                            r_next.st = scr_pkg::SCR_CMD;
                            if (isConvCmd) begin
                                if (r_reg.busy) begin
                                    r_next.corrupt = 1'b1; // RQ5
                                end else begin
                                    r_next.busy = 1'b1; // RQ6
                                    r_next.corrupt = 1'b0;
                                    r_next.convTemp = (r_reg.shift[7:4] == `SCR_CMD_KIND_TEMP); // RQ1
                                    r_next.convCnt = (32'(CONV_BASE_CYCLES) << r_reg.shift[3:1])
                                        - `SCR_COUNT_ONE; // RQ1
                                    r_next.resultValid = 1'b0; // RQ6
                                end
                            end else if (r_reg.shift == `SCR_CMD_ADC_READ) begin
                                r_next.readArmed = 1'b1; // RQ10
                                if (r_reg.busy) begin
                                    r_next.corrupt = 1'b1; // RQ4
                                end
                            end
                        end
                    end
                end
                // data bits change on falling clock, msb first
                scr_pkg::SCR_TX: begin
                    if (sclFall) begin
                        r_next.txWord = {r_reg.txWord[`SCR_RESULT_W-2:0], 1'b0}; // RQ2
                        r_next.bitCnt = r_reg.bitCnt + 3'h1;
                        if (r_reg.bitCnt == `SCR_LAST_BIT) begin
                            r_next.sda.drive = 1'b0; // RQ8
                            r_next.st = scr_pkg::SCR_TX_MACK; // RQ8
                        end else begin
                            r_next.sda.drive = ~r_reg.txWord[`SCR_RESULT_W-2]; // RQ2
                        end
                    end
                end
                // controller acknowledge after each byte
                scr_pkg::SCR_TX_MACK: begin
                    if (sclRise) begin
                        r_next.gotAck = ~sdaS; // RQ8
                    end else if (sclFall) begin
                        if (r_reg.gotAck && (r_reg.byteCnt != `SCR_LAST_BYTE)) begin
                            r_next.byteCnt = r_reg.byteCnt + 2'h1; // RQ7
                            r_next.bitCnt = 3'h0;
                            r_next.sda.drive = ~r_reg.txWord[`SCR_RESULT_W-1]; // RQ7
                            r_next.st = scr_pkg::SCR_TX;
                        end else begin
                            r_next.st = scr_pkg::SCR_IDLE; // nack or all 24 bits sent
                        end
                    end
                end
                default: begin
                    r_next.sda.drive = 1'b0;
                end
            endcase
        end

        // a hit on the finishing cycle still marks the result it lands on
        if (r_reg.busy && !r_next.busy) begin
            r_next.resultCorrupt = r_next.corrupt; // RQ4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register the state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flip-flops
    assign sdaOut = r_reg.sda.level;
    assign sdaOe = r_reg.sda.drive;
    assign convBusy = r_reg.busy;
    assign resultValid = r_reg.resultValid;
    assign resultCorrupt = r_reg.resultCorrupt;
endmodule

`default_nettype wire

/* File: test/scr_readout_monitor.sv */
// concurrent checks on the readout block pins
`timescale 1ns/1ps
`default_nettype none
module scr_readout_monitor #(
    parameter int unsigned CONV_BASE_CYCLES = 1000
) (
    clk_sys, // system clock
    resetn, // async reset, active low
    sclIn, // bus clock pin
    sdaOut, // data drive level
    sdaOe, // data drive enable
    convBusy, // conversion running
    resultValid, // unread result stored
    resultCorrupt // stored result corrupted
);
    input wire logic clk_sys;
    input wire logic resetn;
    input wire logic sclIn;
    input wire logic sdaOut;
    input wire logic sdaOe;
    input wire logic convBusy;
    input wire logic resultValid;
    input wire logic resultCorrupt;
    logic [31:0] busyLen_reg; // cycles of the running conversion
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    // busy length counter, cleared whenever idle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busyLen_reg <= 32'h00000000;
        end else begin
            busyLen_reg <= convBusy ? busyLen_reg + 32'h00000001 : 32'h00000000;
        end
    end
    // conversion ends: busy one cycle, idle the next
    sequence s_finish;
        convBusy ##1 !convBusy;
    endsequence
    ////////////////////////////////////////////////////////////
    property p_drive_low; sdaOut == 1'b0; endproperty
    property p_oe_scl_low; $changed(sdaOe) |-> !sclIn; endproperty
    property p_oe_hold; sclIn [*5] |-> $stable(sdaOe); endproperty
    property p_busy_start; $rose(convBusy) |-> !sclIn; endproperty
    property p_finish_valid; s_finish |-> resultValid; endproperty
    property p_valid_rise; $rose(resultValid) |-> $fell(convBusy); endproperty
    property p_busy_min; s_finish |-> busyLen_reg >= CONV_BASE_CYCLES; endproperty
    property p_busy_max; convBusy |-> busyLen_reg <= CONV_BASE_CYCLES * 32 + 2; endproperty
    property p_corrupt_upd; $changed(resultCorrupt) |-> $fell(convBusy); endproperty
    a_drive_low: assert property (p_drive_low) else $error("data pin driven high");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved with clock high");
    a_oe_hold: assert property (p_oe_hold) else $error("data drive unstable in clock high");
    a_busy_start: assert property (p_busy_start) else $error("busy rose outside ack end");
    a_finish_valid: assert property (p_finish_valid) else $error("no valid result at finish");
    a_valid_rise: assert property (p_valid_rise) else $error("valid rose without finish");
    a_busy_min: assert property (p_busy_min) else $error("conversion too short");
    a_busy_max: assert property (p_busy_max) else $error("conversion too long");
    a_corrupt_upd: assert property (p_corrupt_upd) else $error("corrupt flag moved off finish");
endmodule
bind scr_readout scr_readout_monitor #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) u_scr_readout_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .convBusy(convBusy), .resultValid(resultValid), .resultCorrupt(resultCorrupt));
`default_nettype wire

/* File: test/scr_bus_ctrl.sv */
// bus controller model that frames transfers for the readout block
`timescale 1ns/1ps
`default_nettype none
module scr_bus_ctrl (
    sclOut, // bus clock, still and high between frames
    sdaLow, // controller pulls data low
    sdaWire // resolved data wire
);
    output logic sclOut;
    output logic sdaLow;
    input wire logic sdaWire;
    localparam realtime HALF = 62.5; // half of the 125 ns bus period
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    // data falls while clock high
    task automatic bus_start();
        #HALF sdaLow = 1'b1;
        #HALF sclOut = 1'b0;
    endtask
    // data rises while clock high
    task automatic bus_stop();
        #20 sdaLow = 1'b1;
        #(HALF - 20) sclOut = 1'b1;
        #HALF sdaLow = 1'b0;
        #HALF;
    endtask
    task automatic put_bit(input logic b);
        #20 sdaLow = !b;
        #(HALF - 20) sclOut = 1'b1;
        #HALF sclOut = 1'b0;
    endtask
    // release the line, sample mid clock high
    task automatic get_bit(output logic b);
        #20 sdaLow = 1'b0;
        #(HALF - 20) sclOut = 1'b1;
        #(HALF / 2) b = sdaWire;
        #(HALF / 2) sclOut = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(nack);
    endtask
    // acknowledge each byte, not the last one
    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule
`default_nettype wire

/* File: test/scr_readout_tb.sv */
// self-checking bench for the conversion readout block
`timescale 1ns/1ps
`default_nettype none
module scr_readout_tb;
    localparam int unsigned BASE = 64; // shortened conversion base count
    logic clk_sys = 1'b0; // system clock
    logic resetn = 1'b0; // reset, active low
    logic sclIn; // bus clock from controller
    logic sdaLow; // controller pulls data low
    logic sdaWire; // resolved data wire
    scr_pkg::scr_samples_t samples = '0; // front-end samples
    logic sdaOut, sdaOe, convBusy, resultValid, resultCorrupt; // design outputs
    logic ack; // address acknowledge seen
    int fails = 0;
    int num_checks = 0;
    int seed = 52626;
    int busyCnt = 0, lastBusyLen = 0, expLen = 0;
    logic [23:0] mdlRes = 24'h000000, mdlPend = 24'h000000; // model result store
    logic mdlValid = 1'b0, mdlBusy = 1'b0; // model state
    logic [23:0] expQ[$]; // expected read results
    assign sdaWire = !(sdaLow || sdaOe); // open drain with pull-up
    always #5 clk_sys = ~clk_sys;
    scr_readout #(.CONV_BASE_CYCLES(BASE)) u_scr_readout (.clk_sys(clk_sys), .resetn(resetn), .sclIn(sclIn),
        .sdaIn(sdaWire), .samples(samples), .sdaOut(sdaOut), .sdaOe(sdaOe), .convBusy(convBusy),
        .resultValid(resultValid), .resultCorrupt(resultCorrupt));
    scr_bus_ctrl u_scr_bus_ctrl (.sclOut(sclIn), .sdaLow(sdaLow), .sdaWire(sdaWire));
    // measure how long each conversion stays busy
    always @(posedge clk_sys) begin
        if (convBusy === 1'b1) busyCnt++;
        else if (busyCnt != 0) begin
            lastBusyLen = busyCnt;
            busyCnt = 0;
        end
    end
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t result %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer_cmd(input logic [7:0] cmd);
        logic a1, a2;
        u_scr_bus_ctrl.bus_start();
        u_scr_bus_ctrl.send_byte(8'hec, a1);
        u_scr_bus_ctrl.send_byte(cmd, a2);
        u_scr_bus_ctrl.bus_stop();
        check_bit(a1 | a2, 1'b0);
    endtask
    // new random samples, then a conversion command
    task automatic start_conv(input logic temp, input int oversampling_ratio);
        @(posedge clk_sys);
        #1 samples = scr_pkg::scr_samples_t'({24'($random(seed)), 24'($random(seed))});
        mdlPend = temp ? samples.temperature : samples.pressure;
        mdlBusy = 1'b1;
        expLen = BASE << oversampling_ratio;
        xfer_cmd({3'h2, temp, 3'(oversampling_ratio), 1'b0});
    endtask
    task automatic finish_conv(input logic expCorrupt);
        for (int i = 0; i < 4000 && convBusy !== 1'b0; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        #1;
        mdlBusy = 1'b0;
        mdlValid = 1'b1;
        mdlRes = mdlPend;
        check_bit(convBusy, 1'b0);
        check_bit(resultValid, 1'b1);
        check_bit(resultCorrupt, expCorrupt);
        check_bit(lastBusyLen >= expLen && lastBusyLen <= expLen + 2, 1'b1);
    endtask
    // read command then 24-bit read, checked against the model
    task automatic do_read();
        logic [23:0] got;
        expQ.push_back((mdlValid && !mdlBusy) ? mdlRes : 24'h000000);
        mdlValid = 1'b0;
        xfer_cmd(8'h00);
        u_scr_bus_ctrl.bus_start();
        u_scr_bus_ctrl.send_byte(8'hed, ack);
        check_bit(ack, 1'b0);
        u_scr_bus_ctrl.recv_byte(1'b0, got[23:16]);
        u_scr_bus_ctrl.recv_byte(1'b0, got[15:8]);
        u_scr_bus_ctrl.recv_byte(1'b1, got[7:0]);
        u_scr_bus_ctrl.bus_stop();
        check_val(got, expQ.pop_front());
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        do_read();
        u_scr_bus_ctrl.bus_start();
        u_scr_bus_ctrl.send_byte(8'he0, ack);
        u_scr_bus_ctrl.bus_stop();
        check_bit(ack, 1'b1);
        // out-of-range ratio code and odd low bit must not start a conversion
        xfer_cmd(8'h4c);
        check_bit(convBusy, 1'b0);
        xfer_cmd(8'h41);
        check_bit(convBusy, 1'b0);
        for (int t = 0; t < 2; t++) begin
            for (int o = 0; o < 6; o++) begin
                start_conv(t[0], o);
                finish_conv(1'b0);
                do_read();
                do_read();
            end
        end
        start_conv(1'b0, 5);
        do_read();
        finish_conv(1'b1);
        start_conv(1'b1, 5);
        xfer_cmd(8'h40);
        finish_conv(1'b1);
        start_conv(1'b1, 2);
        finish_conv(1'b0);
        do_read();
        give_verdict();
    end
    // watchdog against a hung bus
    initial begin
        #900000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
